// File: rtl/quadrature_encoder_counter.v
// Incremental encoder counter with index zeroing and raw tally.
`timescale 1ns/1ps
`default_nettype none
`include "quad_counter_defs.vh"
module quadrature_encoder_counter
#(
    parameter HAS_MARKER_GATE = 1,
    parameter SAMPLE_MHZ = `SAMPLE_RATE_33_MHZ
)
(
    // Clock and reset.
    input wire clock,
    input wire reset_n,
    // Encoder inputs.
    input wire phase_a,
    input wire phase_b,
    input wire zero_marker,
    input wire marker_gate,
    // Configuration.
    input wire count_style_select,
    input wire long_filter_select,
    input wire marker_edge_select,
    input wire marker_gating_on,
    input wire gate_level_select,
    // Host control.
    input wire count_reset,
    input wire arm_set,
    // Status.
    output reg arm_zero_on_marker,
    output reg [`COUNT_WIDTH-1:0] count,
    output reg [`COUNT_WIDTH-1:0] total_unadjusted_tally,
    output reg marker_level
);
    // Divide the 250 MHz clock to the sample rate by a phase accumulator.
    // The enable jitters by one clock; the long-run rate stays exact.
    localparam [7:0] RATE_STEP = SAMPLE_MHZ;
    localparam [8:0] RATE_MOD = `CLOCK_RATE_MHZ;
    reg [8:0] rate_acc;
    reg sample_enable;
    reg [8:0] next_rate_acc;
    reg next_sample_enable;
    wire [8:0] rate_sum;
    assign rate_sum = rate_acc + {1'b0, RATE_STEP};
    always @*
    begin
        next_rate_acc = rate_sum;
        next_sample_enable = 1'b0;
        if (rate_sum >= RATE_MOD)
        begin
            next_rate_acc = rate_sum - RATE_MOD;
            next_sample_enable = 1'b1;
        end
    end
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rate_acc <= 9'h000;
            sample_enable <= 1'b0;
        end
        else
        begin
            rate_acc <= next_rate_acc;
            sample_enable <= next_sample_enable;
        end
    end

    // Filter the four inputs; the gate input is tied off when not built.
    wire [3:0] raw_inputs;
    wire [3:0] clean;
    wire gate_in;
    assign gate_in = (HAS_MARKER_GATE != 0) ? marker_gate : 1'b0;
    assign raw_inputs = {gate_in, zero_marker, phase_b, phase_a};
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : filters
            glitch_filter filter_unit
            (
                .clock(clock),
                .reset_n(reset_n),
                .sample_enable(sample_enable),
                .long_filter(long_filter_select),
                .raw_in(raw_inputs[i]),
                .filtered(clean[i])
            );
        end
    endgenerate

    reg [3:0] previous;
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            previous <= 4'h0;
        end
        else
        begin
            previous <= clean;
        end
    end

    // Step codes: a two-bit signed -1, 0 or +1.
    localparam [1:0] STEP_NONE = 2'b00;
    localparam [1:0] STEP_UP = 2'b01;
    localparam [1:0] STEP_DOWN = 2'b11;

    // Quadrature step decode from previous and present A/B states.
    function [1:0] quad_step;
        input [1:0] old_ab;
        input [1:0] new_ab;
        reg [3:0] pair;
        begin
            pair = {old_ab, new_ab};
            case (pair)
                4'b0001: quad_step = STEP_UP;
                4'b0111: quad_step = STEP_UP;
                4'b1110: quad_step = STEP_UP;
                4'b1000: quad_step = STEP_UP;
                4'b0010: quad_step = STEP_DOWN;
                4'b1011: quad_step = STEP_DOWN;
                4'b1101: quad_step = STEP_DOWN;
                4'b0100: quad_step = STEP_DOWN;
                // Both phases moved at once: direction unknown, so no count.
                default: quad_step = STEP_NONE;
            endcase
        end
    endfunction

    // Edge of a filtered input against its value one clock earlier.
    function edge_seen;
        input old_level;
        input new_level;
        input rising;
        begin
            if (rising)
            begin
                edge_seen = new_level && !old_level;
            end
            else
            begin
                edge_seen = old_level && !new_level;
            end
        end
    endfunction

    reg [1:0] step;
    always @*
    begin
        step = STEP_NONE;
        case (count_style_select)
            `STYLE_QUADRATURE:
            begin
                step = quad_step({previous[1], previous[0]},
                                 {clean[1], clean[0]});
            end
            `STYLE_UP_DOWN:
            begin
                if (edge_seen(previous[0], clean[0], 1'b1))
                begin
                    if (clean[1])
                    begin
                        step = STEP_UP;
                    end
                    else
                    begin
                        step = STEP_DOWN;
                    end
                end
            end
            default:
            begin
                step = STEP_NONE;
            end
        endcase
    end

    reg [`COUNT_WIDTH-1:0] step_ext;
    always @*
    begin
        case (step)
            STEP_UP:
            begin
                step_ext = 32'h0000_0001;
            end
            STEP_DOWN:
            begin
                step_ext = 32'hffff_ffff;
            end
            default:
            begin
                step_ext = `COUNT_RESET;
            end
        endcase
    end

    // Marker event from the filtered marker and gate inputs.
    wire marker_edge;
    reg gate_ok;
    wire marker_event;
    wire marker_zeroing;
    assign marker_edge = edge_seen(previous[2], clean[2], marker_edge_select);
    always @*
    begin
        gate_ok = 1'b1;
        if (marker_gating_on && (HAS_MARKER_GATE != 0))
        begin
            gate_ok = (clean[3] != gate_level_select);
        end
    end
    assign marker_event = marker_edge && gate_ok;
    assign marker_zeroing = arm_zero_on_marker && marker_event;

    // The arm bit is host set and device cleared; a host set in the
    // zeroing cycle loses, since the event it waits for already passed.
    reg next_arm;
    always @*
    begin
        next_arm = arm_zero_on_marker;
        if (marker_zeroing)
        begin
            next_arm = 1'b0;
        end
        else if (arm_set)
        begin
            next_arm = 1'b1;
        end
    end

    // The reset input wins over marker zeroing and over any step.
    reg [`COUNT_WIDTH-1:0] next_count;
    reg [`COUNT_WIDTH-1:0] next_tally;
    always @*
    begin
        next_tally = total_unadjusted_tally + step_ext;
        next_count = count + step_ext;
        if (count_reset)
        begin
            next_count = `COUNT_RESET;
        end
        else if (marker_zeroing)
        begin
            next_count = `COUNT_RESET;
        end
    end

    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            arm_zero_on_marker <= 1'b0;
        end
        else
        begin
            arm_zero_on_marker <= next_arm;
        end
    end

    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count <= `COUNT_RESET;
            total_unadjusted_tally <= `COUNT_RESET;
            marker_level <= 1'b0;
        end
        else
        begin
            marker_level <= clean[2];
            total_unadjusted_tally <= next_tally;
            count <= next_count;
        end
    end
endmodule
`default_nettype wire

// File: common/quad_counter_defs.vh
// Constants for the incremental encoder counter.
`ifndef QUAD_COUNTER_DEFS_VH
`define QUAD_COUNTER_DEFS_VH
`define COUNT_WIDTH 32
`define COUNT_RESET 32'h0000_0000
`define FILTER_LONG_CYCLES 4'hf
`define FILTER_SHORT_CYCLES 4'h3
`define FILTER_CNT_WIDTH 4
`define SAMPLE_RATE_33_MHZ 8'h21
`define SAMPLE_RATE_50_MHZ 8'h32
`define CLOCK_RATE_MHZ 9'h0fa
`define STYLE_QUADRATURE 1'b0
`define STYLE_UP_DOWN 1'b1
`endif

// File: rtl/glitch_filter.v
// Stability filter for one encoder input.
`timescale 1ns/1ps
`default_nettype none
`include "quad_counter_defs.vh"
module glitch_filter
(
    // Clock and reset.
    input wire clock,
    input wire reset_n,
    // Control.
    input wire sample_enable,
    input wire long_filter,
    // Data.
    input wire raw_in,
    output reg filtered
);
    reg [`FILTER_CNT_WIDTH-1:0] stable_count;
    wire [`FILTER_CNT_WIDTH-1:0] limit;
    assign limit = long_filter ? `FILTER_LONG_CYCLES : `FILTER_SHORT_CYCLES;
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stable_count <= 4'h0;
            filtered <= 1'b0;
        end
        else if (sample_enable)
        begin
            if (raw_in == filtered)
            begin
                stable_count <= 4'h0;
            end
            // A change must hold for the full count to be accepted.
            else if (stable_count + 4'h1 >= limit)
            begin
                stable_count <= 4'h0;
                filtered <= raw_in;
            end
            else
            begin
                stable_count <= stable_count + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/quad_counter_checker_assertions.sv
// Checker for the encoder counter outputs.
`timescale 1ns/1ps
`default_nettype none
`include "quad_counter_defs.vh"
module quad_counter_checker
(
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // Observed ports.
    input wire logic count_reset,
    input wire logic arm_set,
    input wire logic arm_zero_on_marker,
    input wire logic [`COUNT_WIDTH-1:0] count,
    input wire logic [`COUNT_WIDTH-1:0] total_unadjusted_tally,
    input wire logic marker_level
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    a_reset_holds: assert property (count_reset |=> count == 32'h0)
        else $error("count not held");
    a_arm_zeroes: assert property ($fell(arm_zero_on_marker) |-> count == 0)
        else $error("arm cleared without zeroing");
    a_arm_cause: assert property ($rose(arm_zero_on_marker) |-> $past(arm_set))
        else $error("arm rose without request");
    a_zero_cause: assert property ($changed(count) && count == 32'h0
        && $past(count) != 32'h1 && $past(count) != 32'hffffffff
        |-> $past(arm_zero_on_marker) || $past(count_reset))
        else $error("count zeroed without cause");
    a_count_unit: assert property ($changed(count) |-> count == 32'h0
        || count - $past(count) inside {32'h1, 32'hffffffff})
        else $error("count jumped");
    a_tally_unit: assert property ($changed(total_unadjusted_tally)
        |-> total_unadjusted_tally - $past(total_unadjusted_tally)
        inside {32'h1, 32'hffffffff})
        else $error("tally jumped");
    a_tally_follow: assert property (count == $past(count) + 32'h1
        && !$past(count_reset) && !$past(arm_zero_on_marker)
        |-> total_unadjusted_tally == $past(total_unadjusted_tally) + 32'h1)
        else $error("tally missed a step");
    a_step_spacing: assert property ($changed(total_unadjusted_tally)
        |=> $stable(total_unadjusted_tally) [*3])
        else $error("steps closer than the filter allows");
    a_marker_filter: assert property ($changed(marker_level)
        |=> $stable(marker_level) [*8])
        else $error("marker level flickered");
    c_zeroed: cover property ($fell(arm_zero_on_marker));
    c_reset: cover property (count_reset ##1 count == 32'h0);
    c_marker: cover property ($changed(marker_level));
endmodule
bind quadrature_encoder_counter quad_counter_checker quad_counter_checker_i
    (.clock, .reset_n, .count_reset, .arm_set, .arm_zero_on_marker, .count,
    .total_unadjusted_tally, .marker_level);
`default_nettype wire

// File: verif/encoder_model.sv
// Behavioural quadrature encoder driving phases A and B.
`timescale 1ns/1ps
`default_nettype none
module encoder_model
(
    // Clock.
    input wire logic clock,
    // Motion commands.
    input wire logic step,
    input wire logic dir,
    input wire logic glitch,
    // Encoder phases.
    output logic phase_a,
    output logic phase_b
);
    logic [1:0] pos = 2'h0;
    always @(posedge clock)
    begin
        if (step)
        begin
            pos <= dir ? pos + 2'h1 : pos - 2'h1;
        end
    end
    assign phase_b = pos[1];
    // The glitch input lets the bench disturb A without moving the shaft.
    assign phase_a = pos[1] ^ pos[0] ^ glitch;
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the encoder counter.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests = n_tests + 1; if ((s) !== (e)) \
    begin errors = errors + 1; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, s); end end
module testbench;
    logic clock = 1'b0, reset_n = 1'b0, step = 1'b0, dir = 1'b0;
    logic glitch = 1'b0, zero_marker = 1'b0, marker_gate = 1'b0;
    logic count_style_select = 1'b0, long_filter_select = 1'b1;
    logic marker_edge_select = 1'b1, marker_gating_on = 1'b0;
    logic gate_level_select = 1'b0, count_reset = 1'b0, arm_set = 1'b0;
    wire phase_a, phase_b, arm_zero_on_marker, marker_level;
    wire [31:0] count, total_unadjusted_tally;
    integer errors = 0, n_tests = 0;
    encoder_model encoder_model_i (.clock, .step, .dir, .glitch, .phase_a,
        .phase_b);
    quadrature_encoder_counter quadrature_encoder_counter_i (.clock,
        .reset_n, .phase_a, .phase_b, .zero_marker, .marker_gate,
        .count_style_select, .long_filter_select, .marker_edge_select,
        .marker_gating_on, .gate_level_select, .count_reset, .arm_set,
        .arm_zero_on_marker, .count, .total_unadjusted_tally, .marker_level);
    initial forever #2 clock = ~clock;
    task automatic idle(input integer n);
        repeat (n) @(posedge clock);
    endtask
    task automatic mv(input logic d, input integer n, input integer h);
        repeat (n)
        begin
            step <= 1'b1;
            dir <= d;
            idle(1);
            step <= 1'b0;
            idle(h);
        end
    endtask
    task automatic gl(input integer h);
        glitch <= 1'b1;
        idle(h);
        glitch <= 1'b0;
        idle(40);
    endtask
    task automatic arm();
        arm_set <= 1'b1;
        idle(1);
        arm_set <= 1'b0;
        idle(2);
    endtask
    task automatic wt(input logic [31:0] e);
        integer i;
        for (i = 0; i < 600 && count !== e; i = i + 1) idle(1);
        if (i == 600)
        begin
            errors = errors + 1;
            conclude();
        end
    endtask
    task automatic conclude();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic t_filter();
        gl(90);
        `CHK("long glitch", 32'h0, count)
        mv(1'b1, 1, 200);
        wt(32'h1);
        long_filter_select <= 1'b0;
        gl(10);
        `CHK("short glitch", 32'h1, count)
    endtask
    task automatic t_jump();
        step <= 1'b1;
        dir <= 1'b1;
        idle(1);
        step <= 1'b0;
        glitch <= 1'b1;
        idle(60);
        `CHK("jump up", 32'h1, total_unadjusted_tally)
        step <= 1'b1;
        dir <= 1'b0;
        idle(1);
        step <= 1'b0;
        glitch <= 1'b0;
        idle(60);
        `CHK("jump back", 32'h1, total_unadjusted_tally)
    endtask
    task automatic t_quad();
        mv(1'b1, 3, 40);
        wt(32'h4);
        `CHK("four per line", 32'h4, total_unadjusted_tally)
        mv(1'b0, 2, 40);
        wt(32'h2);
        `CHK("down tally", 32'h2, total_unadjusted_tally)
    endtask
    task automatic t_updown();
        count_style_select <= 1'b1;
        gl(40);
        gl(40);
        mv(1'b1, 2, 40);
        gl(40);
        wt(32'h3);
        `CHK("up down", 32'h3, total_unadjusted_tally)
        count_style_select <= 1'b0;
    endtask
    task automatic t_marker();
        arm();
        `CHK("armed", 1'b1, arm_zero_on_marker)
        zero_marker <= 1'b1;
        wt(32'h0);
        `CHK("arm clear", 1'b0, arm_zero_on_marker)
        `CHK("tally kept", 32'h3, total_unadjusted_tally)
        idle(40);
        `CHK("marker level", 1'b1, marker_level)
        mv(1'b1, 1, 40);
        marker_edge_select <= 1'b0;
        arm();
        zero_marker <= 1'b0;
        wt(32'h0);
        `CHK("falling edge", 1'b0, arm_zero_on_marker)
    endtask
    task automatic t_gate();
        mv(1'b1, 1, 40);
        marker_edge_select <= 1'b1;
        marker_gating_on <= 1'b1;
        arm();
        zero_marker <= 1'b1;
        idle(60);
        `CHK("gated out", 32'h1, count)
        gate_level_select <= 1'b1;
        zero_marker <= 1'b0;
        idle(60);
        `CHK("wrong edge", 1'b1, arm_zero_on_marker)
        marker_gate <= 1'b1;
        idle(60);
        zero_marker <= 1'b1;
        idle(60);
        `CHK("gate high blocks", 32'h1, count)
        marker_gate <= 1'b0;
        zero_marker <= 1'b0;
        idle(60);
        zero_marker <= 1'b1;
        wt(32'h0);
        `CHK("gate low", 1'b0, arm_zero_on_marker)
    endtask
    task automatic t_reset();
        count_reset <= 1'b1;
        mv(1'b1, 1, 40);
        `CHK("held zero", 32'h0, count)
        `CHK("tally runs", 32'h6, total_unadjusted_tally)
        count_reset <= 1'b0;
        mv(1'b1, 1, 40);
        wt(32'h1);
    endtask
    initial
    begin
        idle(10);
        reset_n <= 1'b1;
        idle(2);
        `CHK("reset tally", 32'h0, total_unadjusted_tally)
        t_filter();
        t_jump();
        t_quad();
        t_updown();
        t_marker();
        t_gate();
        t_reset();
        conclude();
    end
endmodule
`default_nettype wire
